// file: design/acc_control.sv
// What this block does
// - converter runs only while on bit set
// - idle stop halts converter in idle
// - slow clock bit picks auxiliary pll
// - global trigger fires pairs selecting it
// - format bit picks fractional or integer
// - early bit: interrupt after first conversion
// - order bit picks odd or even first
// - sequential bit delays shared sample-and-hold
// - five-bit code selects pair trigger
// - irq enable gates pair completion interrupt
// - pending set on trigger, cleared done
// - soft trigger bit self-clears when pending
// - busy core keeps request pending
// Purpose: trigger, sequencing and register logic for one converter pair
// Assumes: core gives one-cycle done pulse per conversion; pins already synchronous
// Notes:   interrupt status bit0 = pair done, write one to clear
`timescale 1ns/1ps
`default_nettype none
module acc_control (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic [3:0]       addr_in,
   input  wire logic [15:0]      wdata_in,
   input  wire logic             wr_in,
   input  wire logic             rd_in,
   output logic      [15:0]      rdata_out,
   input  wire acc_pkg::acc_trig_s trig_in,
   input  wire logic             idle_mode_in,
   input  wire logic             core_done_in,
   input  wire logic [9:0]       core_result_in,
   output var acc_pkg::acc_core_s core_out,
   output logic                  core_enable_out,
   output logic                  clk_sel_aux_out,
   output logic      [2:0]       clk_div_out,
   output logic      [15:0]      result_out,
   output logic                  irq_out
);
   import acc_pkg::*;

   // ************************************************************
   // trigger decode
   // ************************************************************
   // map a five-bit source code onto the hardware trigger lines
   function automatic logic src_hit(input logic [4:0] src, input acc_trig_s t,
                                    input logic sw, input logic gl);
      logic hit;
      hit = 1'b0;
      if (src == SRC_SOFT) hit = sw;
      else if (src == SRC_GLOBAL) hit = gl;
      else if (src == SRC_SPEV) hit = t.special_event;
      else if (src >= SRC_PRI1 && src < SRC_TMR1) hit = t.pwm_primary[3'(src - SRC_PRI1)];
      else if (src == SRC_TMR1) hit = t.timer1_period;
      else if (src == SRC_SSPEV) hit = t.sec_special_event;
      else if (src >= SRC_SEC1 && src < SRC_CL1) hit = t.pwm_secondary[4'(src - SRC_SEC1)];
      else if (src >= SRC_CL1 && src < SRC_TMR2) hit = t.pwm_current_limit[3'(src - SRC_CL1)];
      else if (src == SRC_TMR2) hit = t.timer2_period;
      return hit;
   endfunction

   // ************************************************************
   // state
   // ************************************************************
   logic [15:0] control_q, control_d;
   logic [15:0] pair_q, pair_d;
   logic        stat_q, stat_d;
   logic        mask_q, mask_d;
   logic [15:0] rdata_q, rdata_d;
   logic [15:0] result_q, result_d;
   acc_state_e  state_q, state_d;
   logic        gtrig_q, gtrig_d;
   logic        running, trig_fire, pend, first_done, second_done, irq_event;
   logic        start_pulse, shared_now;
   logic [15:0] ctl_w;

   // running means on and not stopped in idle
   // module on gate
   assign running = control_q[BIT_ON] & ~(control_q[BIT_IDLE] & idle_mode_in);
   // global trigger edge so a held bit fires only once
   // global trigger edge
   assign trig_fire = running & src_hit(pair_q[SRC_LO +: 5], trig_in, pair_q[BIT_SWTRG],
                                        control_q[BIT_GTRIG] & ~gtrig_q);
   assign pend        = pair_q[BIT_PEND];
   assign first_done  = (state_q == ACC_FIRST) & core_done_in;
   assign second_done = (state_q == ACC_SECOND) & core_done_in;
   assign irq_event = pair_q[BIT_IRQEN] &
                      (control_q[BIT_EARLY] ? first_done : second_done);
   assign start_pulse = running & ((state_q == ACC_IDLE & pend) | first_done);

   // ************************************************************
   // register writes and flags
   // ************************************************************
   // next values of control, pair, status and mask
   always_comb begin
      ctl_w     = wdata_in & CONTROL_WMASK;
      control_d = control_q;
      pair_d    = pair_q;
      stat_d    = stat_q;
      mask_d    = mask_q;
      gtrig_d   = control_q[BIT_GTRIG];
      if (wr_in && addr_in == ADDR_CONTROL) begin
         if (control_q[BIT_ON]) begin
            control_d = (control_q & FROZEN_MASK) | (ctl_w & ~FROZEN_MASK);
         end else begin
            control_d = ctl_w;
         end
      end
      if (wr_in && addr_in == ADDR_PAIR_TRIG) begin
         // pending is status only; software sets trigger and enable fields
         pair_d = {3'h0, wdata_in[SRC_LO +: 5], wdata_in[BIT_IRQEN], pair_q[BIT_PEND],
                   wdata_in[BIT_SWTRG], 5'h00};
      end
      if (second_done) begin
         pair_d[BIT_PEND] = 1'b0;
      end
      if (trig_fire) begin
         pair_d[BIT_PEND] = 1'b1;
      end
      if (pend) begin
         pair_d[BIT_SWTRG] = 1'b0;
      end
      if (wr_in && addr_in == ADDR_IRQ_MASK) mask_d = wdata_in[0];
      if (wr_in && addr_in == ADDR_IRQ_STAT && wdata_in[0]) stat_d = 1'b0;
      if (irq_event) stat_d = 1'b1;
   end

   // register the configuration group
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         control_q <= CONTROL_RESET;
         pair_q    <= PAIR_RESET;
         stat_q    <= 1'b0;
         mask_q    <= 1'b0;
         gtrig_q   <= 1'b0;
      end else begin
         control_q <= control_d;
         pair_q    <= pair_d;
         stat_q    <= stat_d;
         mask_q    <= mask_d;
         gtrig_q   <= gtrig_d;
      end
   end

   // ************************************************************
   // conversion sequencer
   // ************************************************************
   // walk a pending pair through two conversions
   always_comb begin
      state_d  = state_q;
      result_d = result_q;
      case (state_q)
         ACC_IDLE: begin
            if (running && pend) state_d = ACC_FIRST;
         end
         ACC_FIRST: begin
            if (!running) state_d = ACC_IDLE;
            else if (core_done_in) state_d = ACC_SECOND;
         end
         ACC_SECOND: begin
            if (!running || core_done_in) state_d = ACC_IDLE;
         end
         default: state_d = ACC_IDLE;
      endcase
      if (core_done_in) begin
         result_d = control_q[BIT_FORM] ? {core_result_in, 6'h00} : {6'h00, core_result_in};
      end
   end

   // register the sequencer group
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_q  <= ACC_IDLE;
         result_q <= 16'h0000;
      end else begin
         state_q  <= state_d;
         result_q <= result_d;
      end
   end

   assign shared_now = control_q[BIT_SEQ] ? (state_q == ACC_FIRST) : (state_q == ACC_IDLE);
   always_comb begin
      core_out.start         = start_pulse;
      core_out.odd_input     = (state_q == ACC_IDLE) ? control_q[BIT_ORDER] : ~control_q[BIT_ORDER];
      core_out.shared_sample = start_pulse & shared_now;
   end
   assign core_enable_out = running;
   assign clk_sel_aux_out = control_q[BIT_SLOW];
   assign clk_div_out     = control_q[2:0];
   assign result_out      = result_q;
   assign irq_out         = stat_q & mask_q;

   // ************************************************************
   // read port
   // ************************************************************
   // read data appear one cycle after the strobe
   always_comb begin
      rdata_d = 16'h0000;
      if (rd_in) begin
         case (addr_in)
            ADDR_CONTROL:   rdata_d = control_q;
            ADDR_PAIR_TRIG: rdata_d = pair_q;
            ADDR_IRQ_STAT:  rdata_d = {15'h0000, stat_q};
            ADDR_IRQ_MASK:  rdata_d = {15'h0000, mask_q};
            default:        rdata_d = 16'h0000;
         endcase
      end
   end

   // register read data
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) rdata_q <= 16'h0000;
      else rdata_q <= rdata_d;
   end
   assign rdata_out = rdata_q;

   // ************************************************************
   // assertions
   // ************************************************************
   on_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !control_q[BIT_ON] |-> !core_out.start && !core_enable_out) else $error("start while off");
   idle_stop_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      control_q[BIT_IDLE] && idle_mode_in |-> !core_enable_out) else $error("run in idle");
   clk_sel_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wr_in && addr_in == ADDR_CONTROL && !control_q[BIT_ON] |=>
      clk_sel_aux_out == $past(wdata_in[BIT_SLOW])) else $error("clock select wrong");
   frozen_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      control_q[BIT_ON] |=> (control_q & FROZEN_MASK) == ($past(control_q) & FROZEN_MASK))
      else $error("config changed while on");
   format_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      core_done_in && !control_q[BIT_FORM] |=> result_out[15:10] == 6'h00)
      else $error("integer upper bits");
   pend_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      trig_fire |=> pend) else $error("pending not set");
   pend_clr_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      second_done && !trig_fire |=> !pend) else $error("pending not cleared");
   sw_clear_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      pend && !(wr_in && addr_in == ADDR_PAIR_TRIG) |=> !pair_q[BIT_SWTRG])
      else $error("soft trigger stuck");
   irq_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !pair_q[BIT_IRQEN] && !stat_q && !(wr_in && addr_in == ADDR_IRQ_STAT) |=> !stat_q)
      else $error("irq without enable");
   early_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      first_done && pair_q[BIT_IRQEN] && control_q[BIT_EARLY] |=> stat_q)
      else $error("early irq missing");
   hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      pend && state_q != ACC_IDLE && !second_done |=> pend) else $error("request lost");
   order_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      start_pulse && state_q == ACC_IDLE |-> core_out.odd_input == control_q[BIT_ORDER])
      else $error("wrong first input");
   two_conv_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      first_done ##[1:50] second_done);
   global_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      trig_fire && pair_q[SRC_LO +: 5] == SRC_GLOBAL);
   irq_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(irq_out));

   // ************************************************************
   // trigger, sequencing and result checks
   // ************************************************************
   global_fire_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      running && control_q[BIT_GTRIG] && !gtrig_q &&
      pair_q[SRC_LO +: 5] == SRC_GLOBAL |=> pend) else $error("global trigger missed");
   global_once_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      control_q[BIT_GTRIG] && gtrig_q && pair_q[SRC_LO +: 5] == SRC_GLOBAL && !pend |=> !pend)
      else $error("held global bit fired again");
   late_irq_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      second_done && pair_q[BIT_IRQEN] && !control_q[BIT_EARLY] |=> stat_q)
      else $error("late irq missing");
   seq_first_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      start_pulse && state_q == ACC_IDLE |-> core_out.shared_sample == !control_q[BIT_SEQ])
      else $error("shared sample at first start");
   seq_second_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      start_pulse && state_q == ACC_FIRST |-> core_out.shared_sample == control_q[BIT_SEQ])
      else $error("shared sample at second start");
   order_second_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      start_pulse && state_q == ACC_FIRST |-> core_out.odd_input != control_q[BIT_ORDER])
      else $error("wrong second input");
   none_code_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      pair_q[SRC_LO +: 5] == SRC_NONE |-> !trig_fire) else $error("code zero triggered");
   frac_align_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      core_done_in && control_q[BIT_FORM] |=> result_out == {$past(core_result_in), 6'h00})
      else $error("fraction misaligned");
   stop_abort_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      state_q != ACC_IDLE && !running |=> state_q == ACC_IDLE)
      else $error("sequence not aborted");
   // main scenario covers
   seq_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      start_pulse && core_out.shared_sample && state_q == ACC_FIRST);
   soft_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      trig_fire && pair_q[SRC_LO +: 5] == SRC_SOFT);
endmodule
`default_nettype wire

// file: design/acc_pkg.sv
// Purpose: shared constants and types for the converter control block
// Assumes: 16-bit registers on a plain strobe port
// Notes:   register offsets are local word addresses
package acc_pkg;
   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [3:0]  ADDR_CONTROL   = 4'h0;
   localparam logic [3:0]  ADDR_PAIR_TRIG = 4'h1;
   localparam logic [3:0]  ADDR_IRQ_STAT  = 4'h2;
   localparam logic [3:0]  ADDR_IRQ_MASK  = 4'h3;
   localparam logic [15:0] CONTROL_RESET  = 16'h0003;
   localparam logic [15:0] CONTROL_WMASK  = 16'hb5f7;
   localparam logic [15:0] PAIR_RESET     = 16'h0000;
   // ************************************************************
   // control and pair trigger bit positions
   // ************************************************************
   localparam int BIT_ON     = 15;
   localparam int BIT_IDLE   = 13;
   localparam int BIT_SLOW   = 12;
   localparam int BIT_GTRIG  = 10;
   localparam int BIT_FORM   = 8;
   localparam int BIT_EARLY  = 7;
   localparam int BIT_ORDER  = 6;
   localparam int BIT_SEQ    = 5;
   localparam int BIT_ASYNC  = 4;
   localparam int BIT_IRQEN  = 7;
   localparam int BIT_PEND   = 6;
   localparam int BIT_SWTRG  = 5;
   localparam int SRC_LO     = 8;
   // frozen while on: format, early, order, seq, async, slow, divider
   localparam logic [15:0] FROZEN_MASK = 16'h11f7;
   // ************************************************************
   // trigger source codes
   // ************************************************************
   localparam logic [4:0] SRC_NONE   = 5'h00;
   localparam logic [4:0] SRC_SOFT   = 5'h01;
   localparam logic [4:0] SRC_GLOBAL = 5'h02;
   localparam logic [4:0] SRC_SPEV   = 5'h03;
   localparam logic [4:0] SRC_PRI1   = 5'h04;
   localparam logic [4:0] SRC_TMR1   = 5'h0c;
   localparam logic [4:0] SRC_SSPEV  = 5'h0d;
   localparam logic [4:0] SRC_SEC1   = 5'h0e;
   localparam logic [4:0] SRC_CL1    = 5'h17;
   localparam logic [4:0] SRC_TMR2   = 5'h1f;
   // conversion sequencing
   typedef enum logic [1:0] {ACC_IDLE, ACC_FIRST, ACC_SECOND} acc_state_e;
   // hardware trigger inputs
   typedef struct packed {
      logic       special_event;
      logic       sec_special_event;
      logic       timer1_period;
      logic       timer2_period;
      logic [7:0] pwm_primary;
      logic [8:0] pwm_secondary;
      logic [7:0] pwm_current_limit;
   } acc_trig_s;
   // commands to the converter core
   typedef struct packed {
      logic start;
      logic odd_input;
      logic shared_sample;
   } acc_core_s;
endpackage

// file: sim/acc_core_model.sv
// Purpose: behavioural converter core answering start pulses
// Assumes: fixed conversion time in clock cycles
// Notes:   result is base xor input parity; result lines toggle when not valid
`timescale 1ns/1ps
`default_nettype none
module acc_core_model #(
   parameter int          LAT  = 8,
   parameter logic [9:0]  BASE = 10'h2a5
) (
   input  wire logic               clk_in,
   input  wire logic               rst_n_in,
   input  wire acc_pkg::acc_core_s cmd_in,
   input  wire logic               enable_in,
   output logic                    done_out,
   output logic      [9:0]         result_out
);
   import acc_pkg::*;
   int   cnt_q;
   logic odd_q;
   // one conversion per start, aborted when switched off
   always_ff @(posedge clk_in) begin
      done_out   <= 1'b0;
      result_out <= ~result_out; // stale data never holds still
      if (!rst_n_in) begin
         cnt_q      <= 0;
         result_out <= 10'h155;
      end else if (!enable_in) begin
         cnt_q <= 0;
      end else if (cmd_in.start) begin
         cnt_q <= LAT;
         odd_q <= cmd_in.odd_input;
      end else if (cnt_q != 0) begin
         cnt_q <= cnt_q - 1;
         if (cnt_q == 1) begin
            done_out   <= 1'b1;
            result_out <= BASE ^ {9'h000, odd_q};
         end
      end
   end
endmodule
`default_nettype wire

// file: sim/test_adc_conversion_control_trigger.sv
// Purpose: self-checking bench for the converter control block
// Assumes: core model answers each start after a fixed count
// Notes:   every nonzero trigger code runs from a table of configurations, odd cases follow
`timescale 1ns/1ps
`default_nettype none
module test_adc_conversion_control_trigger;
   import acc_pkg::*;
   logic        clk_in, rst_n_in, wr_in, rd_in, idle_mode_in, core_done_in;
   logic        core_enable_out, clk_sel_aux_out, irq_out;
   logic [3:0]  addr_in;
   logic [15:0] wdata_in, rdata_out, result_out, v;
   logic [9:0]  core_result_in;
   logic [2:0]  clk_div_out;
   acc_trig_s   trig_in;
   acc_core_s   core_out;
   int          error_cnt, comparisons, cycles;
   logic [15:0] ctrl_tab [4] = '{16'h0003, 16'h1163, 16'h0085, 16'h01d3};
   logic [15:0] res_tab  [4] = '{16'h02a4, 16'ha940, 16'h02a5, 16'ha900};

   acc_control DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .trig_in(trig_in), .idle_mode_in(idle_mode_in), .core_done_in(core_done_in),
      .core_result_in(core_result_in), .core_out(core_out),
      .core_enable_out(core_enable_out), .clk_sel_aux_out(clk_sel_aux_out),
      .clk_div_out(clk_div_out), .result_out(result_out), .irq_out(irq_out));
   acc_core_model #(.LAT(8), .BASE(10'h2a5)) core (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .cmd_in(core_out), .enable_in(core_enable_out), .done_out(core_done_in),
      .result_out(core_result_in));

   // clock and hang guard
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         wrap_up();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // register bus cycles, strobes one cycle long
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_in);
      wr_in    <= 1'b1;
      addr_in  <= a;
      wdata_in <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk_in);
      rd_in   <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask
   task automatic rc(input logic [3:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rd(a, d);
      chk(d, exp);
   endtask
   // wait for a level on the interrupt line, bounded
   task automatic wait_irq(input logic want);
      int n;
      n = 0;
      while (irq_out !== want && n < 100) begin
         @(posedge clk_in);
         #1 n++;
      end
      chk({15'h0, irq_out}, {15'h0, want});
   endtask
   // poll until the pair is no longer pending
   task automatic settle(output logic [15:0] d);
      int n;
      n = 0;
      do begin
         rd(ADDR_PAIR_TRIG, d);
         n++;
      end while (d[BIT_PEND] !== 1'b0 && n < 50);
   endtask
   // one-cycle pulse on the hardware trigger that a code selects
   task automatic pulse(input logic [4:0] c);
      acc_trig_s t;
      t = '0;
      case (c) inside
         5'h03: t.special_event = 1'b1;
         [5'h04:5'h0b]: t.pwm_primary[3'(c - 5'h04)] = 1'b1;
         5'h0c: t.timer1_period = 1'b1;
         5'h0d: t.sec_special_event = 1'b1;
         [5'h0e:5'h16]: t.pwm_secondary[4'(c - 5'h0e)] = 1'b1;
         [5'h17:5'h1e]: t.pwm_current_limit[3'(c - 5'h17)] = 1'b1;
         default: t.timer2_period = 1'b1;
      endcase
      @(posedge clk_in);
      trig_in <= t;
      @(posedge clk_in);
      trig_in <= '0;
   endtask
   task automatic wrap_up();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      {wr_in, rd_in, idle_mode_in, addr_in, wdata_in} = '0;
      trig_in  = '0;
      rst_n_in = 1'b0;
      repeat (10) @(posedge clk_in);
      rst_n_in <= 1'b1;
      #1 chk({13'h0, clk_div_out}, 16'h0003);
      chk({14'h0, irq_out, core_enable_out}, 16'h0000);
      rc(ADDR_CONTROL, 16'h0003);
      rc(ADDR_PAIR_TRIG, 16'h0000);
      rc(ADDR_IRQ_STAT, 16'h0000);
      rc(4'h7, 16'h0000);
      wr(ADDR_IRQ_MASK, 16'h0001);
      // every nonzero trigger code against a rotating configuration row
      for (int s = 1; s < 32; s++) begin
         wr(ADDR_CONTROL, ctrl_tab[s % 4]);
         wr(ADDR_CONTROL, ctrl_tab[s % 4] | 16'h8000);
         #1 chk({11'h0, clk_div_out, clk_sel_aux_out, core_enable_out},
                {11'h0, ctrl_tab[s % 4][2:0], ctrl_tab[s % 4][12], 1'b1});
         wr(ADDR_PAIR_TRIG, {3'h0, 5'(s), 8'h80});
         if (s == 1) begin
            wr(ADDR_PAIR_TRIG, {3'h0, 5'(s), 8'ha0});
         end else if (s == 2) begin
            wr(ADDR_CONTROL, ctrl_tab[s % 4] | 16'h8400);
         end else begin
            pulse(5'(s));
         end
         repeat (2) @(posedge clk_in);
         rc(ADDR_PAIR_TRIG, {3'h0, 5'(s), 8'hc0});
         wait_irq(1'b1);
         chk(result_out, res_tab[s % 4]);
         settle(v);
         chk(v, {3'h0, 5'(s), 8'h80});
         wr(ADDR_IRQ_STAT, 16'h0001);
         wait_irq(1'b0);
      end
      // configuration frozen while on, idle stop still writable
      wr(ADDR_CONTROL, 16'h0003);
      wr(ADDR_CONTROL, 16'h8003);
      wr(ADDR_CONTROL, 16'ha1f4);
      rc(ADDR_CONTROL, 16'ha003);
      @(posedge clk_in);
      idle_mode_in <= 1'b1;
      @(posedge clk_in);
      #1 chk({15'h0, core_enable_out}, 16'h0000);
      wr(ADDR_CONTROL, 16'h8003);
      #1 chk({15'h0, core_enable_out}, 16'h0001);
      @(posedge clk_in);
      idle_mode_in <= 1'b0;
      // soft request while off waits, runs once on, masked interrupt
      wr(ADDR_IRQ_MASK, 16'h0000);
      wr(ADDR_CONTROL, 16'h0003);
      wr(ADDR_PAIR_TRIG, 16'h0180);
      wr(ADDR_PAIR_TRIG, 16'h01a0);
      repeat (2) @(posedge clk_in);
      rc(ADDR_PAIR_TRIG, 16'h01a0);
      wr(ADDR_CONTROL, 16'h8003);
      repeat (2) @(posedge clk_in);
      settle(v);
      chk(v, 16'h0180);
      chk({15'h0, irq_out}, 16'h0000);
      rc(ADDR_IRQ_STAT, 16'h0001);
      wr(ADDR_IRQ_MASK, 16'h0001);
      wait_irq(1'b1);
      wr(ADDR_IRQ_STAT, 16'h0001);
      wait_irq(1'b0);
      // completion without interrupt enable raises no status
      wr(ADDR_PAIR_TRIG, 16'h0100);
      wr(ADDR_PAIR_TRIG, 16'h0120);
      repeat (2) @(posedge clk_in);
      settle(v);
      rc(ADDR_IRQ_STAT, 16'h0000);
      // code zero ignores every trigger line
      wr(ADDR_PAIR_TRIG, 16'h0080);
      @(posedge clk_in);
      trig_in <= '1;
      @(posedge clk_in);
      trig_in <= '0;
      repeat (2) @(posedge clk_in);
      rc(ADDR_PAIR_TRIG, 16'h0080);
      wrap_up();
   end
endmodule
`default_nettype wire
